// file: core/fbp_pkg.sv
// Shared constants and carriers for the flash block protection front end.
// Assumes one system clock and that protection attributes are held elsewhere.
package fbp_pkg;
  localparam int unsigned ADDR_W      = 17;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned WORD_LSB    = 2;
  localparam int unsigned UNIT_LSB    = 10;
  localparam int unsigned REGION_LSB  = 11;
  localparam int unsigned UNIT_W      = ADDR_W - UNIT_LSB;
  localparam int unsigned REGION_W    = ADDR_W - REGION_LSB;
  localparam int unsigned REGIONS     = 64;
  localparam int unsigned WORDS       = 32768;
  localparam int unsigned UWORD_W     = UNIT_LSB - WORD_LSB;
  localparam logic [UWORD_W-1:0] UWORD_LAST = 8'hFF;
  localparam logic [DATA_W-1:0]  ERASED_WORD = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0]  ZERO_WORD   = 32'h00000000;

  typedef enum logic [1:0] {
    FBP_OPEN      = 2'h0,
    FBP_READ_ONLY = 2'h1,
    FBP_EXEC_ONLY = 2'h2,
    FBP_EXEC_ALT  = 2'h3
  } fbp_attr_type;

  typedef enum logic [4:0] {
    FBP_FETCH = 5'h01,
    FBP_DREAD = 5'h02,
    FBP_DEBUG = 5'h04,
    FBP_PROG  = 5'h08,
    FBP_ERASE = 5'h10
  } fbp_kind_type;

  typedef enum logic [1:0] {
    FBP_IDLE    = 2'h1,
    FBP_ERASING = 2'h2
  } fbp_state_type;

  typedef struct packed {
    logic              valid;
    fbp_kind_type      kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } fbp_req_type;

  typedef struct packed {
    logic              valid;
    logic              denied;
    logic [DATA_W-1:0] data;
  } fbp_rsp_type;
endpackage : fbp_pkg

// file: core/fbp_region_check.sv
// Permission decision for one access against its region attribute.
// Assumes attribute and kind are stable in the request cycle.
`timescale 1ns/1ps
`default_nettype none
module fbp_region_check (
  input  wire fbp_pkg::fbp_attr_type attr,
  input  wire fbp_pkg::fbp_kind_type kind,
  output logic                       allow
);
  always_comb begin
    case (attr)
      fbp_pkg::FBP_OPEN:      allow = 1'b1;
      fbp_pkg::FBP_READ_ONLY: allow = (kind != fbp_pkg::FBP_PROG) &&
                                      (kind != fbp_pkg::FBP_ERASE);
      // Execute-only and code 3 alike: the stricter setting, fetch only
      default:                allow = (kind == fbp_pkg::FBP_FETCH);
    endcase
  end
endmodule : fbp_region_check
`default_nettype wire

// file: core/fbp_top.sv
// Flash array front end enforcing erase units and region protection.
// Assumes requests arrive on core_clk and attributes come from outside storage.
`timescale 1ns/1ps
`default_nettype none
module fbp_top (
  input  wire logic                                core_clk,
  input  wire logic                                nrst,
  input  wire fbp_pkg::fbp_req_type                req,
  output logic                                     reqReady,
  input  wire logic [2*fbp_pkg::REGIONS-1:0]       protAttr,
  input  wire logic                                violClr,
  output fbp_pkg::fbp_rsp_type                     rsp,
  output logic                                     busy,
  output logic                                     eraseDone,
  output logic                                     violation
);
  logic [fbp_pkg::DATA_W-1:0]      flashMem [fbp_pkg::WORDS];
  fbp_pkg::fbp_state_type          state_r;
  logic [fbp_pkg::UNIT_W-1:0]      eraseUnit_r;
  logic [fbp_pkg::UWORD_W-1:0]     eraseCnt_r;
  logic                            eraseDone_r;
  logic                            violation_r;
  fbp_pkg::fbp_rsp_type            rsp_r;
  logic [fbp_pkg::REGION_W-1:0]    regionSel;
  logic [fbp_pkg::UNIT_W-1:0]      unitSel;
  logic [14:0]                     wordSel;
  logic [14:0]                     eraseIdx;
  fbp_pkg::fbp_attr_type           attrSel;
  logic                            allow;
  logic                            accept;
  logic                            isRead;
  logic                            refuse;

  // Read kinds, decoded for the answer path and its checks alike
  function automatic logic isReadKind(input fbp_pkg::fbp_kind_type kind);
    isReadKind = (kind == fbp_pkg::FBP_FETCH) || (kind == fbp_pkg::FBP_DREAD) ||
                 (kind == fbp_pkg::FBP_DEBUG);
  endfunction : isReadKind

  assign unitSel   = req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::UNIT_LSB];
  assign regionSel = req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::REGION_LSB];
  assign wordSel   = req.addr[fbp_pkg::ADDR_W-1:fbp_pkg::WORD_LSB];
  assign eraseIdx  = {eraseUnit_r, eraseCnt_r};
  assign attrSel   = fbp_pkg::fbp_attr_type'(protAttr[2*regionSel +: 2]);
  // No new request while a unit erase is running
  assign reqReady  = (state_r == fbp_pkg::FBP_IDLE);
  assign accept    = req.valid && reqReady;
  assign isRead    = isReadKind(req.kind);
  assign refuse    = accept && !allow;
  assign busy      = (state_r == fbp_pkg::FBP_ERASING);
  assign eraseDone = eraseDone_r;
  assign violation = violation_r;
  assign rsp       = rsp_r;

  fbp_region_check uCheck (
    .attr  (attrSel),
    .kind  (req.kind),
    .allow (allow)
  );

  // Erase sequencing, one word per cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= fbp_pkg::FBP_IDLE;
      eraseUnit_r <= '0;
      eraseCnt_r  <= '0;
      eraseDone_r <= 1'b0;
    end else begin
      eraseDone_r <= 1'b0;
      case (state_r)
        fbp_pkg::FBP_IDLE: begin
          if (accept && allow && req.kind == fbp_pkg::FBP_ERASE) begin
            state_r     <= fbp_pkg::FBP_ERASING;
            eraseUnit_r <= unitSel;
            eraseCnt_r  <= '0;
          end
        end
        fbp_pkg::FBP_ERASING: begin
          eraseCnt_r <= eraseCnt_r + 1'b1;
          if (eraseCnt_r == fbp_pkg::UWORD_LAST) begin
            state_r     <= fbp_pkg::FBP_IDLE;
            eraseDone_r <= 1'b1;
          end
        end
        default: state_r <= fbp_pkg::FBP_IDLE;
      endcase
    end
  end

  // Array has no reset: its contents are meant to persist
  always_ff @(posedge core_clk) begin
    if (state_r == fbp_pkg::FBP_ERASING) begin
      flashMem[eraseIdx] <= fbp_pkg::ERASED_WORD;
    end else if (accept && allow && req.kind == fbp_pkg::FBP_PROG) begin
      // Programming only clears bits, as flash cells do
      flashMem[wordSel] <= flashMem[wordSel] & req.wdata;
    end
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rsp_r <= '0;
    end else begin
      rsp_r.valid  <= accept;
      rsp_r.denied <= refuse;
      if (accept && allow && isRead) begin
        rsp_r.data <= flashMem[wordSel];
      end else begin
        rsp_r.data <= fbp_pkg::ZERO_WORD;
      end
    end
  end

  // Sticky flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      violation_r <= 1'b0;
    end else if (refuse) begin
      violation_r <= 1'b1;
    end else if (violClr) begin
      violation_r <= 1'b0;
    end
  end

  logic modReq;
  logic readReq;
  assign modReq  = (req.kind == fbp_pkg::FBP_PROG) || (req.kind == fbp_pkg::FBP_ERASE);
  assign readReq = (req.kind == fbp_pkg::FBP_DREAD) || (req.kind == fbp_pkg::FBP_DEBUG);

  sequence eraseStartS;
    accept && allow && req.kind == fbp_pkg::FBP_ERASE;
  endsequence

  sequence eraseRunS;
    busy [*8] ##248 busy ##1 (eraseDone && !busy);
  endsequence

  eraseLen_a: assert property (@(posedge core_clk) disable iff (!nrst)
    eraseStartS |=> eraseRunS)
    else $error("erase did not span one unit of words");

  eraseOnes_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |=> flashMem[$past(eraseIdx)] == fbp_pkg::ERASED_WORD)
    else $error("erased word not all ones");

  regionPair_a: assert property (@(posedge core_clk) disable iff (!nrst)
    req.valid |-> regionSel == unitSel[fbp_pkg::UNIT_W-1:1])
    else $error("unit halves split across regions");

  openAllow_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && attrSel == fbp_pkg::FBP_OPEN |=> rsp.valid && !rsp.denied)
    else $error("open region access refused");

  roRefuse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && attrSel == fbp_pkg::FBP_READ_ONLY |=> rsp.denied == $past(modReq) && !busy)
    else $error("read-only region decision wrong");

  xoRefuse_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && attrSel == fbp_pkg::FBP_EXEC_ONLY && modReq |=> rsp.denied && !busy)
    else $error("execute-only region modified");

  xoRead_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && attrSel == fbp_pkg::FBP_EXEC_ONLY && readReq
      |=> rsp.denied && rsp.data == fbp_pkg::ZERO_WORD)
    else $error("execute-only region leaked data");

  readOne_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && allow && isRead |=> rsp.valid && !rsp.denied ##1 !rsp.valid || $past(accept))
    else $error("permitted read not answered next cycle");

  violSticky_a: assert property (@(posedge core_clk) disable iff (!nrst)
    refuse |=> violation until_with violClr && !refuse)
    else $error("violation flag lost before clear");

  violBound_a: assert property (@(posedge core_clk) disable iff (!nrst)
    violation && violClr && !refuse |=> !violation)
    else $error("violation flag did not clear");

  // Busy length counted here; a long repetition would choke the tools
  logic [8:0] busyLen_r;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busyLen_r <= '0;
    end else if (busy) begin
      busyLen_r <= busyLen_r + 1'b1;
    end else begin
      busyLen_r <= '0;
    end
  end

  busyLen_a: assert property (@(posedge core_clk) disable iff (!nrst)
    busy |-> busyLen_r <= {1'b0, fbp_pkg::UWORD_LAST})
    else $error("erase ran past one unit");

  doneOnce_a: assert property (@(posedge core_clk) disable iff (!nrst)
    eraseDone |=> !eraseDone)
    else $error("erase done held too long");

  progKeep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    refuse && req.kind == fbp_pkg::FBP_PROG
      |=> flashMem[$past(wordSel)] == $past(flashMem[wordSel]))
    else $error("refused program changed the array");

  xoFetch_a: assert property (@(posedge core_clk) disable iff (!nrst)
    accept && (attrSel == fbp_pkg::FBP_EXEC_ONLY || attrSel == fbp_pkg::FBP_EXEC_ALT) &&
      req.kind == fbp_pkg::FBP_FETCH |=> rsp.valid && !rsp.denied)
    else $error("execute-only fetch refused");

  rspOnce_a: assert property (@(posedge core_clk) disable iff (!nrst)
    rsp.valid |-> $past(accept))
    else $error("answer without a request");

  denyZero_a: assert property (@(posedge core_clk) disable iff (!nrst)
    refuse && isRead |=> rsp.denied && rsp.data == fbp_pkg::ZERO_WORD)
    else $error("refused read returned data");

  violCause_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(violation) |-> $past(refuse))
    else $error("violation raised without a refusal");
endmodule : fbp_top
`default_nettype wire

// file: tb/fbp_host_model.sv
// Request source standing for instruction fetch, data bus and debugger.
// Assumes calls start just after a rising edge of core_clk.
`timescale 1ns/1ps
`default_nettype none
module fbp_host_model (
  input  wire logic                 core_clk,
  input  wire logic                 reqReady,
  output var  fbp_pkg::fbp_req_type req
);
  initial req = '0;
  // Holds the request until taken; released address and data show inverse values
  task automatic issue(input fbp_pkg::fbp_kind_type k, input logic [16:0] a,
                       input logic [31:0] d);
    // One idle edge first, so valid never falls and rises in one time step
    @(posedge core_clk);
    #1;
    req.valid = 1'b1;
    req.kind  = k;
    req.addr  = a;
    req.wdata = d;
    do @(posedge core_clk); while (reqReady !== 1'b1);
    #1;
    req.valid = 1'b0;
    req.addr  = ~a;
    req.wdata = ~d;
  endtask : issue
endmodule : fbp_host_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the flash protection front end.
// Assumes erases finish within a few hundred cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                 core_clk;
  logic                 nrst;
  logic [127:0]         protAttr;
  logic                 violClr;
  logic                 reqReady;
  logic                 busy;
  logic                 eraseDone;
  logic                 violation;
  fbp_pkg::fbp_req_type req;
  fbp_pkg::fbp_rsp_type rsp;
  int                   error_cnt;
  int                   n_compared;
  int                   cycles;
  fbp_host_model fbp_host_model_i (.core_clk(core_clk), .reqReady(reqReady), .req(req));
  fbp_top fbp_top_i (.core_clk(core_clk), .nrst(nrst), .req(req), .reqReady(reqReady),
    .protAttr(protAttr), .violClr(violClr), .rsp(rsp), .busy(busy),
    .eraseDone(eraseDone), .violation(violation));
  always #12.5 core_clk = ~core_clk;
  task automatic complete_run();
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // Generous ceiling: three erases dominate the run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One access, answer checked one cycle after it is taken
  task automatic op(input fbp_pkg::fbp_kind_type k, input logic [16:0] a,
                    input logic [31:0] d, input logic den, input logic [31:0] exp);
    int i;
    fbp_host_model_i.issue(k, a, d);
    check({31'h0, rsp.valid}, 32'h1);
    check({31'h0, rsp.denied}, {31'h0, den});
    check(rsp.data, exp);
    if (k == fbp_pkg::FBP_ERASE && !den) begin
      i = 0;
      while (eraseDone !== 1'b1 && i < 400) begin
        @(posedge core_clk);
        #1;
        i++;
      end
      check(i, 32'h100);
      check({31'h0, eraseDone}, 32'h1);
      check({31'h0, busy}, 32'h0);
    end
  endtask : op
  task automatic t_open();
    op(fbp_pkg::FBP_ERASE, 17'h00400, 32'h0, 1'b0, 32'h0);
    op(fbp_pkg::FBP_PROG, 17'h00400, 32'h12345678, 1'b0, 32'h0);
    op(fbp_pkg::FBP_ERASE, 17'h00000, 32'h0, 1'b0, 32'h0);
    op(fbp_pkg::FBP_DREAD, 17'h003FC, 32'h0, 1'b0, 32'hFFFFFFFF);
    op(fbp_pkg::FBP_DREAD, 17'h00400, 32'h0, 1'b0, 32'h12345678);
  endtask : t_open
  task automatic t_read_only();
    protAttr[1:0] = 2'h1;
    op(fbp_pkg::FBP_ERASE, 17'h00400, 32'h0, 1'b1, 32'h0);
    @(posedge core_clk);
    #1;
    check({31'h0, violation}, 32'h1);
    op(fbp_pkg::FBP_PROG, 17'h00400, 32'h0, 1'b1, 32'h0);
    op(fbp_pkg::FBP_ERASE, 17'h00000, 32'h0, 1'b1, 32'h0);
    op(fbp_pkg::FBP_DREAD, 17'h00400, 32'h0, 1'b0, 32'h12345678);
    op(fbp_pkg::FBP_ERASE, 17'h00800, 32'h0, 1'b0, 32'h0);
    op(fbp_pkg::FBP_DREAD, 17'h00800, 32'h0, 1'b0, 32'hFFFFFFFF);
  endtask : t_read_only
  // Code 3 is exercised too, since it also means execute-only
  task automatic t_exec_only();
    for (int c = 2; c < 4; c++) begin
      protAttr[1:0] = c[1:0];
      op(fbp_pkg::FBP_FETCH, 17'h00400, 32'h0, 1'b0, 32'h12345678);
      op(fbp_pkg::FBP_DREAD, 17'h00400, 32'h0, 1'b1, 32'h0);
      op(fbp_pkg::FBP_DEBUG, 17'h00400, 32'h0, 1'b1, 32'h0);
      op(fbp_pkg::FBP_ERASE, 17'h00000, 32'h0, 1'b1, 32'h0);
      op(fbp_pkg::FBP_PROG, 17'h00400, 32'h0, 1'b1, 32'h0);
      op(fbp_pkg::FBP_FETCH, 17'h00400, 32'h0, 1'b0, 32'h12345678);
    end
  endtask : t_exec_only
  task automatic t_viol_clr();
    violClr = 1'b1;
    @(posedge core_clk);
    #1;
    check({31'h0, violation}, 32'h0);
    // Clear still held: the refusal must win
    op(fbp_pkg::FBP_DEBUG, 17'h00404, 32'h0, 1'b1, 32'h0);
    check({31'h0, violation}, 32'h1);
    violClr = 1'b0;
    @(posedge core_clk);
    #1;
    check({31'h0, violation}, 32'h1);
  endtask : t_viol_clr
  initial begin
    core_clk   = 1'b0;
    nrst       = 1'b0;
    protAttr   = '0;
    violClr    = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    cycles     = 0;
    repeat (2) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_open();
    t_read_only();
    t_exec_only();
    t_viol_clr();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
